/* csbu_pkg.sv */
// Contract
// - compare immediate sets flags, one cycle
// - compare-skip skips next when registers equal
// - register bit clear skips, flags unchanged
// - register bit set skips, flags unchanged
// - io bit clear skips, flags unchanged
// - io bit set skips next instruction
// - flag set branch to pc+k+1
// - flag clear branch to pc+k+1
// - same-or-higher branches on carry clear
// - signed greater-or-equal branch provided
package csbu_pkg;

  // status flag bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;

  localparam logic [7:0]  FLAGS_RESET = 8'h00;
  localparam logic [15:0] PC_RESET    = 16'h0000;
  localparam logic [15:0] PC_ONE      = 16'h0001;
  localparam logic [15:0] PC_TWO      = 16'h0002;
  localparam logic [15:0] PC_THREE    = 16'h0003;

  // wishbone register offsets (byte addresses)
  localparam logic [3:0] REG_FLAGS  = 4'h0;
  localparam logic [3:0] REG_PC     = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;

  typedef enum logic [3:0] {
    CSBU_OP_NONE,
    CSBU_OP_CMP,
    CSBU_OP_CMPC,
    CSBU_OP_CMPI,
    CSBU_OP_CMP_SKIP,
    CSBU_OP_SRB_LOW,
    CSBU_OP_SRB_HIGH,
    CSBU_OP_SIO_LOW,
    CSBU_OP_SIO_HIGH,
    CSBU_OP_BR_HIGH,
    CSBU_OP_BR_LOW,
    CSBU_OP_BR_UGE,
    CSBU_OP_BR_SGE,
    CSBU_OP_BR_SLT
  } csbu_op_type;

  // one decoded instruction from the fetch stage
  typedef struct packed {
    csbu_op_type op;
    logic [7:0]  dst_val;    // first operand register
    logic [7:0]  src_val;    // second operand register or immediate
    logic [7:0]  io_val;     // addressed i/o register
    logic [2:0]  bit_sel;    // bit or flag number
    logic [6:0]  offset;     // signed branch offset
    logic        next_long;  // following instruction is two words
  } csbu_instr_type;

  // flag result of a compare
  typedef struct packed {
    logic       write;
    logic [7:0] flags;
  } csbu_flags_type;

endpackage

/* csbu_compare.sv */
`timescale 1ns/10ps
// subtractor producing compare flags; difference itself is never stored
module csbu_compare (
  input  wire logic [7:0]          a,
  input  wire logic [7:0]          b,
  input  wire logic                cin,
  input  wire logic                keep_z,
  input  wire logic [7:0]          flags_in,
  output csbu_pkg::csbu_flags_type res
);
  logic [8:0] diff;
  logic       n;
  logic       v;
  logic       z;

  // subtract with borrow; carry out of bit 7 is the unsigned borrow
  always_comb begin
    diff = {1'b0, a} - {1'b0, b} - {8'h00, cin};
    n    = diff[7];
    v    = (a[7] & ~b[7] & ~diff[7]) | (~a[7] & b[7] & diff[7]);
    z    = (diff[7:0] == 8'h00) & (~keep_z | flags_in[csbu_pkg::FLAG_Z]);
    res.write = 1'b1;
    res.flags = flags_in;
    res.flags[csbu_pkg::FLAG_C] = diff[8];
    res.flags[csbu_pkg::FLAG_Z] = z;
    res.flags[csbu_pkg::FLAG_N] = n;
    res.flags[csbu_pkg::FLAG_V] = v;
    res.flags[csbu_pkg::FLAG_S] = n ^ v;
    res.flags[csbu_pkg::FLAG_H] = (~a[3] & b[3]) | (b[3] & diff[3]) | (diff[3] & ~a[3]);
  end
endmodule

/* csbu_core.sv */
// The Wishbone interface to the registers and the register addresses were decided locally.
`timescale 1ns/10ps
// compare, skip and branch execution with a wishbone view of flags and pc
// an instruction is taken at an edge where instr_valid meets instr_ready;
// compares and untaken work finish at that edge, a taken branch or a
// one-word skip one edge later, and a two-word skip two edges later;
// pc only moves once the work is done, so the cycle count shows on pc
// one decoded instruction per edge at best; there is no queue
// limitation: next_long comes from fetch, this block never decodes it
// bus side: classic wishbone, one wait state on every access
module csbu_core (
  input  wire logic                    clk,
  input  wire logic                    arst_n,
  input  wire csbu_pkg::csbu_instr_type instr,
  input  wire logic                    instr_valid,
  output logic                         instr_ready,
  output logic [15:0]                  pc,
  output logic [7:0]                   status_flags_register,
  output logic                         busy,
  input  wire logic [31:0]             wb_adr_i,
  input  wire logic [31:0]             wb_dat_i,
  input  wire logic [3:0]              wb_sel_i,
  input  wire logic                    wb_we_i,
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  output logic [31:0]                  wb_dat_o,
  output logic                         wb_ack_o
);
  logic [15:0]              pc_r;
  logic [7:0]               flags_r;
  logic [1:0]               stall_r;   // extra cycles still owed
  logic [15:0]              pc_hold_r; // target applied when stall ends
  logic                     ack_r;
  logic [31:0]              dat_r;
  logic [7:0]               last_op_r;
  csbu_pkg::csbu_flags_type cmp_res;
  logic                     cond;
  logic                     is_branch;
  logic                     is_skip;
  logic                     is_cmp;
  logic [15:0]              target;
  logic [15:0]              koff;
  logic                     accept;
  logic                     wb_hit;
  // decoded strobes, kept apart so each process reads one condition
  logic                     taken;     // branch or skip whose condition holds
  logic                     wb_wr;     // bus write taken this edge
  logic                     wb_rd;     // bus read taken this edge
  logic                     pc_wr;     // bus write aimed at the pc
  logic                     flags_wr;  // bus write aimed at the flags byte

  // ready drops for exactly the cycles a taken branch or skip still owes
  assign accept      = instr_valid & (stall_r == 2'd0);
  assign instr_ready = (stall_r == 2'd0);
  assign busy        = (stall_r != 2'd0);
  assign pc          = pc_r;
  assign status_flags_register = flags_r;
  assign wb_ack_o    = ack_r;
  assign wb_dat_o    = dat_r;
  assign wb_hit      = wb_cyc_i & wb_stb_i & ~ack_r;

  // bus strobes; ack_r masks wb_hit so one request is taken only once
  assign wb_wr       = wb_hit & wb_we_i;
  assign wb_rd       = wb_hit & ~wb_we_i;
  // a pc write is refused while a branch or skip still owes cycles
  assign pc_wr       = wb_wr & (wb_adr_i[3:0] == csbu_pkg::REG_PC) & (stall_r == 2'd0);
  assign flags_wr    = wb_wr & (wb_adr_i[3:0] == csbu_pkg::REG_FLAGS) & wb_sel_i[0];

  // flag update; compare with carry keeps zero only if it was already set
  // one subtractor serves all three compare forms
  csbu_compare u_cmp (
    .a        (instr.dst_val),
    .b        (instr.src_val),
    .cin      ((instr.op == csbu_pkg::CSBU_OP_CMPC) & flags_r[csbu_pkg::FLAG_C]),
    .keep_z   (instr.op == csbu_pkg::CSBU_OP_CMPC),
    .flags_in (flags_r),
    .res      (cmp_res)
  );

  // sign-extend the seven-bit offset to pc width
  assign koff = {{9{instr.offset[6]}}, instr.offset};

  // condition decode per opcode
  always_comb begin
    cond      = 1'b0;
    is_branch = 1'b0;
    is_skip   = 1'b0;
    is_cmp    = 1'b0;
    unique case (instr.op)
      csbu_pkg::CSBU_OP_NONE: cond = 1'b0;
      csbu_pkg::CSBU_OP_CMP, csbu_pkg::CSBU_OP_CMPC, csbu_pkg::CSBU_OP_CMPI: begin
        is_cmp = 1'b1;
      end
      csbu_pkg::CSBU_OP_CMP_SKIP: begin
        is_skip = 1'b1;
        cond    = (instr.dst_val == instr.src_val);
      end
      // register-bit skips test the second operand register
      csbu_pkg::CSBU_OP_SRB_LOW: begin
        is_skip = 1'b1;
        cond    = ~instr.src_val[instr.bit_sel];
      end
      csbu_pkg::CSBU_OP_SRB_HIGH: begin
        is_skip = 1'b1;
        cond    = instr.src_val[instr.bit_sel];
      end
      csbu_pkg::CSBU_OP_SIO_LOW: begin
        is_skip = 1'b1;
        cond    = ~instr.io_val[instr.bit_sel];
      end
      csbu_pkg::CSBU_OP_SIO_HIGH: begin
        is_skip = 1'b1;
        cond    = instr.io_val[instr.bit_sel];
      end
      csbu_pkg::CSBU_OP_BR_HIGH: begin
        is_branch = 1'b1;
        cond      = flags_r[instr.bit_sel];
      end
      csbu_pkg::CSBU_OP_BR_LOW: begin
        is_branch = 1'b1;
        cond      = ~flags_r[instr.bit_sel];
      end
      csbu_pkg::CSBU_OP_BR_UGE: begin
        is_branch = 1'b1;
        cond      = ~flags_r[csbu_pkg::FLAG_C];
      end
      // signed tests read the flags left by the last compare
      csbu_pkg::CSBU_OP_BR_SGE: begin
        is_branch = 1'b1;
        cond      = ~(flags_r[csbu_pkg::FLAG_N] ^ flags_r[csbu_pkg::FLAG_V]);
      end
      csbu_pkg::CSBU_OP_BR_SLT: begin
        is_branch = 1'b1;
        cond      = flags_r[csbu_pkg::FLAG_N] ^ flags_r[csbu_pkg::FLAG_V];
      end
      default: cond = 1'b0;
    endcase
  end

  // next pc: branch target pc+k+1, skip target pc+2 or pc+3
  // wrap at the top of program space is silent, as for the pc itself
  always_comb begin
    target = pc_r + csbu_pkg::PC_ONE;
    if (is_branch && cond) begin
      target = pc_r + koff + csbu_pkg::PC_ONE;
    end else if (is_skip && cond) begin
      target = instr.next_long ? pc_r + csbu_pkg::PC_THREE : pc_r + csbu_pkg::PC_TWO;
    end
  end

  // taken work owes extra cycles; flags are never touched by it
  assign taken = cond & (is_branch | is_skip);

  // stall counter: taken branch owes one cycle, skip owes one or two
  // target is latched because fetch may change instr while ready is low
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stall_r   <= 2'd0;
      pc_hold_r <= csbu_pkg::PC_RESET;
    end else if (accept && taken) begin
      stall_r   <= (is_skip && instr.next_long) ? 2'd2 : 2'd1;
      pc_hold_r <= target;
    end else if (stall_r != 2'd0) begin // nothing is accepted while counting
      stall_r <= stall_r - 2'd1;
    end
  end

  // pc moves when the instruction finishes, so cycle count is visible on pc
  // priority: finishing work, then a new instruction, then a bus write;
  // a bus write that meets an accepted untaken instruction is dropped on purpose
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pc_r <= csbu_pkg::PC_RESET;
    end else if (stall_r == 2'd1) begin
      pc_r <= pc_hold_r;
    end else if (accept && !taken) begin
      pc_r <= target;
    end else if (pc_wr) begin
      pc_r <= wb_dat_i[15:0];
    end
  end

  // flags change only on compares and bus writes; skips and branches leave them alone
  // a compare in the same cycle as a bus write wins over the write
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      flags_r <= csbu_pkg::FLAGS_RESET;
    end else if (accept && is_cmp) begin
      flags_r <= cmp_res.flags;
    end else if (flags_wr) begin
      flags_r <= wb_dat_i[7:0];
    end
  end

  // last accepted opcode kept for software visibility
  // only the low nibble carries the opcode; the upper bits read as zero
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      last_op_r <= 8'h00;
    end else if (accept) begin
      last_op_r <= {4'h0, instr.op};
    end
  end

  // wishbone slave: single wait, ack one cycle after strobe, unmapped reads zero
  // trade-off: a write lands on the taking edge, one cycle before ack shows
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_r <= 1'b0;
      dat_r <= 32'h00000000;
    end else begin
      ack_r <= wb_hit;
      if (wb_rd) begin
        unique case (wb_adr_i[3:0])
          csbu_pkg::REG_FLAGS:  dat_r <= {24'h000000, flags_r};
          csbu_pkg::REG_PC:     dat_r <= {16'h0000, pc_r};
          csbu_pkg::REG_STATUS: dat_r <= {16'h0000, last_op_r, 6'h00, stall_r};
          default:              dat_r <= 32'h00000000;
        endcase
      end
    end
  end
endmodule

/* csbu_core_properties.sv */
`timescale 1ns/10ps
// port-level checks of compare, skip and branch timing
module csbu_core_properties (
  input wire logic                     clk,
  input wire logic                     arst_n,
  input wire csbu_pkg::csbu_instr_type instr,
  input wire logic                     instr_valid,
  input wire logic                     instr_ready,
  input wire logic [15:0]              pc,
  input wire logic [7:0]               status_flags_register,
  input wire logic                     busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic                  tk;
  logic [7:0]            fl;
  logic [15:0]           tgt;
  csbu_pkg::csbu_op_type op;
  // accepted instruction and its relative target
  assign tk  = instr_valid && instr_ready;
  assign fl  = status_flags_register;
  assign op  = instr.op;
  assign tgt = pc + {{9{instr.offset[6]}}, instr.offset} + 16'h0001;
  // taken branch: one stall cycle, then the target
  sequence jump_s;
    busy ##1 (instr_ready && pc == $past(tgt, 2));
  endsequence
  // two-word skip: two stall cycles
  sequence long_skip_s;
    busy[*2] ##1 (instr_ready && pc == $past(pc, 3) + 16'h0003);
  endsequence
  flag_set_jump_a: assert property (
    tk && op == csbu_pkg::CSBU_OP_BR_HIGH && fl[instr.bit_sel] |=> jump_s)
    else $error("flag set branch wrong");
  flag_clr_stay_a: assert property (
    tk && op == csbu_pkg::CSBU_OP_BR_LOW && fl[instr.bit_sel]
    |=> instr_ready && pc == $past(pc) + 16'h0001 && $stable(fl))
    else $error("flag clear branch wrong");
  unsigned_ge_a: assert property (
    tk && op == csbu_pkg::CSBU_OP_BR_UGE && !fl[0] |=> jump_s)
    else $error("same or higher branch wrong");
  signed_ge_a: assert property (
    tk && op == csbu_pkg::CSBU_OP_BR_SGE && !(fl[2] ^ fl[3]) |=> jump_s)
    else $error("signed ge branch wrong");
  cmp_imm_flags_a: assert property (
    tk && op == csbu_pkg::CSBU_OP_CMPI |=> instr_ready
    && fl[1] == ($past(instr.dst_val) == $past(instr.src_val))
    && fl[0] == ($past(instr.dst_val) < $past(instr.src_val)))
    else $error("compare immediate flags wrong");
  long_skip_a: assert property (
    tk && op == csbu_pkg::CSBU_OP_SRB_LOW && !instr.src_val[instr.bit_sel]
    && instr.next_long |=> long_skip_s)
    else $error("long skip wrong");
  io_skip_flags_a: assert property (
    tk && (op == csbu_pkg::CSBU_OP_SIO_LOW || op == csbu_pkg::CSBU_OP_SIO_HIGH)
    |=> $stable(fl)) else $error("io skip touched flags");
  equal_skip_a: assert property (
    tk && op == csbu_pkg::CSBU_OP_CMP_SKIP && instr.dst_val == instr.src_val
    && !instr.next_long |=> busy ##1 pc == $past(pc, 2) + 16'h0002)
    else $error("compare skip wrong");
  reg_bit_skip_a: assert property (
    tk && op == csbu_pkg::CSBU_OP_SRB_HIGH && instr.src_val[instr.bit_sel]
    && !instr.next_long |=> busy ##1 (pc == $past(pc, 2) + 16'h0002 && $stable(fl)))
    else $error("register bit skip wrong");
endmodule

bind csbu_core csbu_core_properties u_csbu_core_properties (.clk, .arst_n, .instr,
  .instr_valid, .instr_ready, .pc, .status_flags_register, .busy);

/* csbu_fetch_model.sv */
`timescale 1ns/10ps
// fetch stage stand-in: offers one decoded instruction at a time
module csbu_fetch_model (
  input wire logic          clk,
  input wire logic          instr_ready,
  output csbu_pkg::csbu_instr_type instr,
  output logic              instr_valid
);
  initial begin
    instr = '0;
    instr_valid = 1'b0;
  end
  // hold the offer until an edge sees ready
  task automatic send(input csbu_pkg::csbu_instr_type i);
    instr <= i;
    instr_valid <= 1'b1;
    do @(posedge clk); while (instr_ready !== 1'b1);
  endtask
  // scramble fields on release so stale data is never trusted
  task automatic idle();
    instr <= ~instr;
    instr_valid <= 1'b0;
  endtask
endmodule

/* tb.sv */
`timescale 1ns/10ps
// drives the core through compares, skips and branches
module tb;
  logic                     clk, arst_n, busy, instr_ready, instr_valid;
  logic                     wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o;
  logic [3:0]               wb_sel_i;
  logic [7:0]               status_flags_register;
  logic [15:0]              pc, epc;
  logic [31:0]              wb_adr_i, wb_dat_i, wb_dat_o, q;
  csbu_pkg::csbu_instr_type instr;
  int                       fails = 0, n_compared = 0, cyc = 0;
  csbu_core u_csbu_core (.clk, .arst_n, .instr, .instr_valid, .instr_ready, .pc,
    .status_flags_register, .busy, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i,
    .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o);
  csbu_fetch_model u_csbu_fetch_model (.clk, .instr_ready, .instr, .instr_valid);
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // run needs about a hundred cycles; ceiling leaves wide margin
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails++;
      tally_and_finish();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one classic cycle, then a gap so cyc drops
  task automatic wb(input logic [31:0] a, d, input logic we);
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_we_i <= we;
    wb_sel_i <= 4'hF;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    do @(posedge clk); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk);
  endtask
  // issue one instruction, count its cycles, compare pc
  task automatic ex(input csbu_pkg::csbu_op_type op, input logic [7:0] d, s,
    input logic [2:0] b, input logic [6:0] k, input logic nl,
    input logic [15:0] dl, input int nc);
    int n;
    u_csbu_fetch_model.send('{op, d, s, s, b, k, nl});
    u_csbu_fetch_model.idle();
    n = 1;
    #1;
    while (busy === 1'b1 && n < 9) begin
      @(posedge clk);
      #1;
      n++;
    end
    epc = epc + dl;
    chk("pc", {16'h0000, epc}, {16'h0000, pc});
    chk("cycles", nc, n);
    @(posedge clk);
  endtask
  task automatic t_regs();
    wb(32'h00000000, 32'h00000000, 1'b0);
    chk("flags", 32'h00000000, q);
    wb(32'h0000000C, 32'h00000000, 1'b0);
    chk("unmapped", 32'h00000000, q);
    wb(32'h00000004, 32'h00000100, 1'b1);
    wb(32'h00000004, 32'h00000000, 1'b0);
    chk("pc reg", 32'h00000100, q);
    epc = 16'h0100;
    $display("registers done");
  endtask
  task automatic t_cmp();
    ex(csbu_pkg::CSBU_OP_CMPI, 8'h10, 8'h20, 3'h0, 7'h00, 1'b0, 16'h0001, 1);
    chk("flags", 32'h00000015, {24'h0, status_flags_register});
    ex(csbu_pkg::CSBU_OP_CMPC, 8'h21, 8'h20, 3'h0, 7'h00, 1'b0, 16'h0001, 1);
    chk("flags", 32'h00000000, {24'h0, status_flags_register});
    ex(csbu_pkg::CSBU_OP_CMP, 8'h80, 8'h01, 3'h0, 7'h00, 1'b0, 16'h0001, 1);
    chk("flags", 32'h00000038, {24'h0, status_flags_register});
    ex(csbu_pkg::CSBU_OP_CMPI, 8'h33, 8'h33, 3'h0, 7'h00, 1'b0, 16'h0001, 1);
    chk("flags", 32'h00000002, {24'h0, status_flags_register});
    ex(csbu_pkg::CSBU_OP_CMP_SKIP, 8'h5A, 8'h5A, 3'h0, 7'h00, 1'b0, 16'h0002, 2);
    ex(csbu_pkg::CSBU_OP_CMP_SKIP, 8'h5A, 8'h5B, 3'h0, 7'h00, 1'b1, 16'h0001, 1);
    $display("compare done");
  endtask
  // every bit-skip op, one- and two-word successors
  task automatic t_skip();
    logic [7:0] v;
    for (int j = 0; j < 8; j++) begin
      v = j[1] ? 8'hFF : 8'h00;
      ex(csbu_pkg::csbu_op_type'(5 + j / 2), v, v, j[2:0], 7'h00, j[0],
        16'(2 + j[0]), 2 + j[0]);
    end
    ex(csbu_pkg::CSBU_OP_SRB_LOW, 8'hFF, 8'h00, 3'h2, 7'h00, 1'b0, 16'h0002, 2);
    ex(csbu_pkg::CSBU_OP_SRB_HIGH, 8'hFF, 8'h00, 3'h3, 7'h00, 1'b1, 16'h0001, 1);
    chk("flags", 32'h00000002, {24'h0, status_flags_register});
    $display("skip done");
  endtask
  task automatic t_branch();
    wb(32'h00000000, 32'h00000009, 1'b1);
    ex(csbu_pkg::CSBU_OP_BR_HIGH, 8'h00, 8'h00, 3'h0, 7'h7E, 1'b0, 16'hFFFF, 2);
    ex(csbu_pkg::CSBU_OP_BR_LOW, 8'h00, 8'h00, 3'h0, 7'h7E, 1'b0, 16'h0001, 1);
    ex(csbu_pkg::CSBU_OP_BR_UGE, 8'h00, 8'h00, 3'h0, 7'h05, 1'b0, 16'h0001, 1);
    ex(csbu_pkg::CSBU_OP_BR_SGE, 8'h00, 8'h00, 3'h0, 7'h05, 1'b0, 16'h0001, 1);
    ex(csbu_pkg::CSBU_OP_BR_SLT, 8'h00, 8'h00, 3'h0, 7'h3F, 1'b0, 16'h0040, 2);
    wb(32'h00000000, 32'h00000000, 1'b1);
    ex(csbu_pkg::CSBU_OP_BR_UGE, 8'h00, 8'h00, 3'h0, 7'h05, 1'b0, 16'h0006, 2);
    ex(csbu_pkg::CSBU_OP_BR_SGE, 8'h00, 8'h00, 3'h0, 7'h05, 1'b0, 16'h0006, 2);
    wb(32'h00000008, 32'h00000000, 1'b0);
    chk("status", 32'h00000C00, q);
    $display("branch done");
  endtask
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    arst_n = 1'b0;
    wb_adr_i = '0;
    wb_dat_i = '0;
    wb_sel_i = 4'h1;
    wb_we_i = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_cmp();
    t_skip();
    t_branch();
    tally_and_finish();
  end
endmodule
